// [srrb_pkg.sv]
package srrb_pkg;

  // ****************************************************************
  // Bus map
  // ****************************************************************
  localparam int          SRRB_AW          = 8;
  localparam logic [7:0]  OFF_CMP_WORD     = 8'h00;
  localparam logic [7:0]  OFF_ALARM_WORD   = 8'h04;
  localparam logic [7:0]  OFF_PMU_CTRL     = 8'h08;
  localparam logic [7:0]  OFF_INT_STAT     = 8'h0c;
  localparam logic [7:0]  OFF_INT_CLR      = 8'h10;
  localparam logic [7:0]  OFF_INT_EN       = 8'h14;
  localparam logic [7:0]  OFF_PMU_RB0      = 8'h18;
  localparam logic [7:0]  OFF_PMU_RB3      = 8'h24;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int          NUM_CH           = 4;
  localparam int          NUM_EVT          = 9;
  localparam logic [1:0]  CMP_TYPE         = 2'h1;
  localparam logic [1:0]  ALARM_TYPE       = 2'h3;
  localparam int          TYPE_HI_POS      = 23;
  localparam int          CMP_BASE_POS     = 21;
  localparam int          TEMP_LAT_POS     = 21;
  localparam int          TEMP_LIVE_POS    = 20;
  localparam int          GUARD_BASE_POS   = 19;
  localparam int          CLAMP_BASE_POS   = 11;
  localparam int          PMU_CLR_POS      = 6;
  localparam int          PMU_RB_LAT_POS   = 6;
  localparam int          PMU_RB_LIVE_POS  = 5;
  localparam logic [23:0] CMP_WORD_RST     = 24'h400000;
  localparam logic [23:0] ALARM_WORD_RST   = 24'hfffff0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0] cmp_low;
    logic [3:0] cmp_high;
    logic       temp;
    logic [3:0] guard;
    logic [3:0] clamp;
  } srrb_pins_t;

  localparam srrb_pins_t PINS_RST = '{cmp_low: 4'h0, cmp_high: 4'h0,
                                      temp: 1'h1, guard: 4'hf,
                                      clamp: 4'hf};

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } srrb_wb_req_t;

  typedef struct packed {
    srrb_pins_t  s1;
    srrb_pins_t  s2;
    logic        lt_temp;
    logic [3:0]  lt_guard;
    logic [3:0]  lt_clamp;
    logic [8:0]  int_stat;
    logic [8:0]  int_en;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic        tmp_oe;
    logic        cg_oe;
  } srrb_state_t;

endpackage : srrb_pkg

// [srrb_top.sv]
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module srrb_top
  import srrb_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire srrb_wb_req_t wb_req_i,
  output var  logic         wb_ack_o,
  output var  logic [31:0]  wb_dat_o,
  input  wire srrb_pins_t   pins_i,
  output var  logic         irq_o,
  output var  logic         temp_alarm_pin_o,
  output var  logic         temp_alarm_pin_oe_o,
  output var  logic         clamp_guard_alarm_pin_o,
  output var  logic         clamp_guard_alarm_pin_oe_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam srrb_state_t STATE_RST = '{
    s1:       PINS_RST,
    s2:       PINS_RST,
    lt_temp:  1'h1,
    lt_guard: 4'hf,
    lt_clamp: 4'hf,
    int_stat: 9'h000,
    int_en:   9'h000,
    ack:      1'h0,
    rdata:    32'h0000_0000,
    irq:      1'h0,
    tmp_oe:   1'h1,
    cg_oe:    1'h1
  };

  srrb_state_t state_reg;
  srrb_state_t state_next;

  logic [23:0] cmp_word;
  logic [23:0] alarm_word;
  logic [23:0] pmu_rb_word;
  logic        bus_hit;
  logic        bus_wr;
  logic        clr_latch;
  logic [8:0]  evt;
  logic [31:0] wmask;

  // ****************************************************************
  // Readback words
  // ****************************************************************
  always_comb begin
    cmp_word = 24'h000000;
    cmp_word[TYPE_HI_POS -: 2] = CMP_TYPE;
    for (int i = 0; i < NUM_CH; i++) begin
      cmp_word[CMP_BASE_POS - 2*i]     = state_reg.s2.cmp_low[i];
      cmp_word[CMP_BASE_POS - 2*i - 1] = state_reg.s2.cmp_high[i];
    end
  end

  always_comb begin
    alarm_word = 24'h000000;
    alarm_word[TYPE_HI_POS -: 2] = ALARM_TYPE;
    // One device-wide temperature pair
    alarm_word[TEMP_LAT_POS]  = state_reg.lt_temp;
    alarm_word[TEMP_LIVE_POS] = state_reg.tmp_oe;
    for (int i = 0; i < NUM_CH; i++) begin
      alarm_word[GUARD_BASE_POS - 2*i]     = state_reg.lt_guard[i];
      alarm_word[GUARD_BASE_POS - 2*i - 1] = state_reg.s2.guard[i];
      alarm_word[CLAMP_BASE_POS - 2*i]     = state_reg.lt_clamp[i];
      alarm_word[CLAMP_BASE_POS - 2*i - 1] = state_reg.s2.clamp[i];
    end
  end

  // Only the temperature pair is modelled in the channel readback
  always_comb begin
    pmu_rb_word = 24'h000000;
    pmu_rb_word[PMU_RB_LAT_POS]  = state_reg.lt_temp;
    pmu_rb_word[PMU_RB_LIVE_POS] = state_reg.tmp_oe;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    bus_hit = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
    bus_wr  = bus_hit & wb_req_i.we;
    wmask   = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
               {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    clr_latch = bus_wr & (wb_req_i.adr == OFF_PMU_CTRL) &
                wb_req_i.sel[0] & wb_req_i.dat[PMU_CLR_POS];

    // Two flops per pin; only the second one is looked at
    state_next.s1 = pins_i;
    state_next.s2 = state_reg.s1;

    // A latch going from clear to set is the interrupt event
    evt = {state_reg.tmp_oe & ~state_reg.lt_temp,
           state_reg.s2.guard & ~state_reg.lt_guard,
           state_reg.s2.clamp & ~state_reg.lt_clamp};

    // A live alarm beats a clear in the same cycle
    state_next.lt_temp  = state_reg.tmp_oe |
                          (state_reg.lt_temp & ~clr_latch);
    state_next.lt_guard = state_reg.s2.guard |
                          (state_reg.lt_guard & {4{~clr_latch}});
    state_next.lt_clamp = state_reg.s2.clamp |
                          (state_reg.lt_clamp & {4{~clr_latch}});

    // Pins are driven low while the alarm stands
    state_next.tmp_oe = state_reg.s2.temp;
    state_next.cg_oe  = |{state_reg.s2.guard, state_reg.s2.clamp};

    // Set wins over clear
    state_next.int_stat = evt;
    if (bus_wr && wb_req_i.adr == OFF_INT_CLR) begin
      state_next.int_stat = evt |
        (state_reg.int_stat & ~(wb_req_i.dat[8:0] & wmask[8:0]));
    end else begin
      state_next.int_stat = evt | state_reg.int_stat;
    end
    if (bus_wr && wb_req_i.adr == OFF_INT_EN) begin
      state_next.int_en = (state_reg.int_en & ~wmask[8:0]) |
                          (wb_req_i.dat[8:0] & wmask[8:0]);
    end
    state_next.irq = |(state_next.int_stat & state_next.int_en);

    // Status words ignore writes; unmapped reads return zero
    state_next.ack = bus_hit;
    if (bus_hit && !wb_req_i.we) begin
      if (wb_req_i.adr == OFF_CMP_WORD) begin
        state_next.rdata = {8'h00, cmp_word};
      end else if (wb_req_i.adr == OFF_ALARM_WORD) begin
        state_next.rdata = {8'h00, alarm_word};
      end else if (wb_req_i.adr == OFF_INT_STAT) begin
        state_next.rdata = {23'h000000, state_reg.int_stat};
      end else if (wb_req_i.adr == OFF_INT_EN) begin
        state_next.rdata = {23'h000000, state_reg.int_en};
      end else if (wb_req_i.adr >= OFF_PMU_RB0 &&
                   wb_req_i.adr <= OFF_PMU_RB3 &&
                   wb_req_i.adr[1:0] == 2'h0) begin
        state_next.rdata = {8'h00, pmu_rb_word};
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open-drain pins only ever pull low
  assign wb_ack_o                   = state_reg.ack;
  assign wb_dat_o                   = state_reg.rdata;
  assign irq_o                      = state_reg.irq;
  assign temp_alarm_pin_o           = 1'b0;
  assign temp_alarm_pin_oe_o        = state_reg.tmp_oe;
  assign clamp_guard_alarm_pin_o    = 1'b0;
  assign clamp_guard_alarm_pin_oe_o = state_reg.cg_oe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pins_still;
    $stable(pins_i) [*3];
  endsequence

  sequence s_clear_write;
    clr_latch && !state_reg.tmp_oe;
  endsequence

  sequence s_quiet_clear;
    clr_latch && !(|state_reg.s2.guard) && !(|state_reg.s2.clamp);
  endsequence

  sequence s_read_take;
    wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !wb_ack_o;
  endsequence

  a_cmp_type_bits:
    assert property (cmp_word[23:22] == 2'b01)
    else $error("comparator word type wrong");

  a_cmp_unused_zero:
    assert property (cmp_word[13:0] == 14'h0000)
    else $error("comparator unused bits not zero");

  a_cmp_follow_pin:
    assert property (s_pins_still |->
                     cmp_word[21] == pins_i.cmp_low[0] &&
                     cmp_word[14] == pins_i.cmp_high[3])
    else $error("comparator bit does not follow pin");

  a_cmp_ch0_high:
    assert property (s_pins_still |->
                     cmp_word[20] == pins_i.cmp_high[0] &&
                     cmp_word[19] == pins_i.cmp_low[1])
    else $error("comparator channel bits misplaced");

  a_cmp_ch1_ch2:
    assert property (s_pins_still |->
                     cmp_word[18] == pins_i.cmp_high[1] &&
                     cmp_word[17] == pins_i.cmp_low[2] &&
                     cmp_word[16] == pins_i.cmp_high[2])
    else $error("comparator middle bits do not follow pins");

  a_cmp_ch3_low:
    assert property (s_pins_still |->
                     cmp_word[15] == pins_i.cmp_low[3])
    else $error("comparator channel 3 low bit wrong");

  a_alarm_type_low:
    assert property (alarm_word[23:22] == 2'b11 &&
                     alarm_word[3:0] == 4'h0)
    else $error("alarm type or unused bits wrong");

  a_guard_live_pin:
    assert property (s_pins_still |->
                     alarm_word[18] == pins_i.guard[0] &&
                     alarm_word[16] == pins_i.guard[1] &&
                     alarm_word[14] == pins_i.guard[2] &&
                     alarm_word[12] == pins_i.guard[3])
    else $error("live guard bit does not follow pin");

  a_clamp_live_pin:
    assert property (s_pins_still |->
                     alarm_word[10] == pins_i.clamp[0] &&
                     alarm_word[8] == pins_i.clamp[1] &&
                     alarm_word[6] == pins_i.clamp[2] &&
                     alarm_word[4] == pins_i.clamp[3])
    else $error("live clamp bit does not follow pin");

  a_live_on_pin:
    assert property (alarm_word[20] == temp_alarm_pin_oe_o)
    else $error("live temperature bit differs from pin");

  a_temp_live_set:
    assert property (state_reg.s2.temp |=>
                     alarm_word[20] && temp_alarm_pin_oe_o)
    else $error("temperature alarm not shown");

  a_temp_live_clr:
    assert property (!state_reg.s2.temp |=>
                     !alarm_word[20] && !temp_alarm_pin_oe_o)
    else $error("temperature alarm shown while quiet");

  a_temp_event_latch:
    assert property (alarm_word[20] |=> alarm_word[21])
    else $error("temperature event not latched");

  a_latch_holds:
    assert property (alarm_word[21] && !clr_latch |=>
                     alarm_word[21])
    else $error("latched temperature bit dropped");

  a_guard_latch_holds:
    assert property (alarm_word[13] && !clr_latch |=> alarm_word[13])
    else $error("latched guard bit dropped");

  a_latch_clears:
    assert property (s_clear_write |=> !alarm_word[21])
    else $error("latched temperature bit not cleared");

  a_quiet_clear:
    assert property (s_quiet_clear |=>
                     (alarm_word[19:4] & 16'haaaa) == 16'h0000)
    else $error("latched guard or clamp bits not cleared");

  a_guard_latch:
    assert property (state_reg.s2.guard[0] |=>
                     alarm_word[19])
    else $error("guard latch not set");

  a_clamp_latch:
    assert property (state_reg.s2.clamp[3] |=> alarm_word[5])
    else $error("clamp latch not set");

  a_cg_pin_live:
    assert property (|{state_reg.s2.guard, state_reg.s2.clamp} |=>
                     clamp_guard_alarm_pin_oe_o)
    else $error("shared alarm pin not pulled");

  a_cg_pin_idle:
    assert property (!(|{state_reg.s2.guard, state_reg.s2.clamp}) |=>
                     !clamp_guard_alarm_pin_oe_o)
    else $error("shared alarm pin pulled while quiet");

  a_open_drain_low:
    assert property (!temp_alarm_pin_o && !clamp_guard_alarm_pin_o)
    else $error("open-drain pin data not low");

  a_pmu_rb_temp:
    assert property (pmu_rb_word[6] == alarm_word[21] &&
                     pmu_rb_word[5] == alarm_word[20])
    else $error("channel readback temperature mismatch");

  a_pmu_rb_live:
    assert property (state_reg.s2.temp |=> pmu_rb_word[5])
    else $error("channel readback live bit not set");

  a_read_cmp_word:
    assert property (s_read_take ##0 (wb_req_i.adr == OFF_CMP_WORD) |=>
                     wb_dat_o[31:22] == 10'h001)
    else $error("comparator read data type wrong");

  a_read_alarm_word:
    assert property (s_read_take ##0 (wb_req_i.adr == OFF_ALARM_WORD) |=>
                     wb_dat_o[31:22] == 10'h003 &&
                     wb_dat_o[3:0] == 4'h0)
    else $error("alarm read data type wrong");

  a_reset_words:
    assert property (disable iff (1'b0)
                     $past(rst_i) && !rst_i |->
                     alarm_word == ALARM_WORD_RST &&
                     cmp_word == CMP_WORD_RST)
    else $error("reset readback words wrong");

  a_wb_ack_pulse:
    assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=>
                     wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");

  a_irq_level:
    assert property (irq_o ==
                     |(state_reg.int_stat & state_reg.int_en))
    else $error("interrupt output wrong");

endmodule : srrb_top

`default_nettype wire

// [srrb_host.sv]
`timescale 1ns/1ps
`default_nettype none

module srrb_host
  import srrb_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         ack_i,
  input  wire logic [31:0]  dat_i,
  output var  srrb_wb_req_t req_o,
  output var  logic         to_o
);
  // ****************************************************************
  // Host side of the register bus
  // ****************************************************************
  initial begin
    req_o = '0;
    to_o  = 1'b0;
  end

  // Request held until ack is sampled, then dropped for a full cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    req_o <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (ack_i !== 1'b1) begin
      to_o = 1'b1;
    end
    q = dat_i;
    req_o <= '0;
    @(posedge clk_i);
  endtask : xfer
endmodule : srrb_host

`default_nettype wire

// [srrb_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module srrb_tb_top;
  import srrb_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  srrb_wb_req_t req;
  srrb_pins_t   pins = PINS_RST;
  logic         ack;
  logic         irq;
  logic         toe;
  logic         cgoe;
  logic         tdat;
  logic         cgdat;
  logic         to;
  logic [31:0]  rdat;
  int           fails = 0;
  int           samples_checked = 0;

  always #50 clk = ~clk;

  srrb_top i_srrb_top (.clk_i(clk), .rst_i(rst), .wb_req_i(req),
    .wb_ack_o(ack), .wb_dat_o(rdat), .pins_i(pins), .irq_o(irq),
    .temp_alarm_pin_o(tdat), .temp_alarm_pin_oe_o(toe),
    .clamp_guard_alarm_pin_o(cgdat), .clamp_guard_alarm_pin_oe_o(cgoe));

  srrb_host i_srrb_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
    .req_o(req), .to_o(to));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic results();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    i_srrb_host.xfer(w, a, d, q);
    if (to) begin
      fails++;
      results();
    end
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  // Pins cross two sync flops, the live temperature flop and the latch stage, so four edges suffice
  task automatic set_pins(input srrb_pins_t p);
    @(posedge clk);
    pins <= p;
    repeat (4) @(posedge clk);
  endtask : set_pins

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(OFF_CMP_WORD, 32'h00400000);
    rd(OFF_ALARM_WORD, 32'h00fffff0);
    chk({31'h0, toe}, 32'h1);
    chk({30'h0, tdat, cgdat}, 32'h0);
  endtask : t_reset

  task automatic t_cmp();
    srrb_pins_t p;
    p = PINS_RST;
    for (int i = 0; i < 8; i++) begin
      p.cmp_low = (i % 2 == 0) ? 4'h1 << (i / 2) : 4'h0;
      p.cmp_high = (i % 2 == 1) ? 4'h1 << (i / 2) : 4'h0;
      set_pins(p);
      rd(OFF_CMP_WORD, 32'h00400000 | (32'h1 << (21 - i)));
    end
    wr(OFF_CMP_WORD, 32'hffffffff);
    rd(OFF_CMP_WORD, 32'h00404000);
  endtask : t_cmp

  task automatic t_clear();
    set_pins('0);
    rd(OFF_ALARM_WORD, 32'h00eaaaa0);
    wr(OFF_ALARM_WORD, 32'h0);
    rd(OFF_ALARM_WORD, 32'h00eaaaa0);
    wr(OFF_PMU_CTRL, 32'h40);
    rd(OFF_ALARM_WORD, 32'h00c00000);
    rd(OFF_PMU_RB0, 32'h0);
    rd(8'h80, 32'h0);
  endtask : t_clear

  task automatic t_events();
    srrb_pins_t p;
    p = '0;
    p.temp = 1'b1;
    p.guard = 4'h2;
    p.clamp = 4'h4;
    wr(OFF_INT_EN, 32'h20);
    set_pins(p);
    rd(OFF_ALARM_WORD, 32'h00f300c0);
    chk({30'h0, toe, cgoe}, 32'h3);
    rd(OFF_PMU_RB3, 32'h60);
    rd(OFF_INT_STAT, 32'h124);
    chk({31'h0, irq}, 32'h1);
    set_pins('0);
    rd(OFF_ALARM_WORD, 32'h00e20080);
    chk({30'h0, toe, cgoe}, 32'h0);
    wr(OFF_INT_CLR, 32'h20);
    rd(OFF_INT_STAT, 32'h104);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_PMU_CTRL, 32'h40);
    rd(OFF_ALARM_WORD, 32'h00c00000);
  endtask : t_events

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cmp();
    t_clear();
    t_events();
    results();
  end
endmodule : srrb_tb_top

`default_nettype wire
